// ### verilog/hdt_pkg.sv
// Constants of the graphics function's configuration header tail.
// Assumes dword-wide configuration cycles with byte enables on one clock.
package hdt_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Byte offsets in configuration space
   localparam logic [7:0]  OFS_SUBSYSTEM_IDENT      = 8'h2e;
   localparam logic [7:0]  OFS_ROM_BASE_WINDOW      = 8'h30;
   localparam logic [7:0]  OFS_FIRST_CAPABILITY     = 8'h34;
   localparam logic [7:0]  OFS_IRQ_ROUTING_LINE     = 8'h3c;
   localparam logic [7:0]  OFS_IRQ_PIN_SELECT       = 8'h3d;
   localparam logic [7:0]  OFS_MIN_GRANT_VALUE      = 8'h3e;
   localparam logic [7:0]  OFS_MAX_LATENCY_VALUE    = 8'h3f;
   localparam logic [7:0]  OFS_MIRRORED_CAPABILITY  = 8'h44;
   localparam logic [7:0]  OFS_VENDOR_CAP_BLOCK     = 8'h48;
   localparam logic [7:0]  OFS_VENDOR_CAP_BLOCK_MID = 8'h4c;
   localparam logic [7:0]  OFS_VENDOR_CAP_BLOCK_TOP = 8'h50;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset and fixed values
   localparam logic [15:0] RST_SUBSYSTEM_IDENT      = 16'h0000;
   localparam logic [31:0] RST_ROM_BASE_WINDOW      = 32'h0000_0000;
   localparam logic [7:0]  VAL_CAP_POWER_MGMT       = 8'hd0;
   localparam logic [7:0]  VAL_CAP_MSI              = 8'h90;
   localparam logic [7:0]  RST_IRQ_ROUTING_LINE     = 8'h00;
   localparam logic [7:0]  VAL_IRQ_PIN_SELECT       = 8'h01;
   localparam logic [7:0]  VAL_MIN_GRANT            = 8'h00;
   localparam logic [7:0]  VAL_MAX_LATENCY          = 8'h00;
   localparam logic [7:0]  VAL_MIRRORED_CAPABILITY  = 8'he0;
   localparam logic [3:0]  VAL_CAPABILITY_VERSION   = 4'h1;
   localparam logic [7:0]  VAL_CAPABILITY_LENGTH    = 8'h09;
   localparam logic [7:0]  VAL_NEXT_CAPABILITY      = 8'h00;
   localparam logic [7:0]  VAL_CAPABILITY_ID        = 8'h09;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions of the vendor capability block (low dword)
   localparam int          POS_CAPABILITY_VERSION   = 24;
   localparam int          POS_CAPABILITY_LENGTH    = 16;
   localparam int          POS_NEXT_CAPABILITY      = 8;
   localparam int          POS_CAPABILITY_ID        = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode hit indexes
   localparam int          HIT_SUBSYS  = 0;
   localparam int          HIT_ROM     = 1;
   localparam int          HIT_CAPPTR  = 2;
   localparam int          HIT_IRQ     = 3;
   localparam int          HIT_MIRROR  = 4;
   localparam int          HIT_CAPBLK0 = 5;
   localparam int          HIT_CAPBLK1 = 6;
   localparam int          HIT_CAPBLK2 = 7;
   localparam int          HIT_COUNT   = 8;

endpackage

// ### verilog/hdt_reg_if.sv
// Write strobe and stored value of one configuration field.
// Assumes controller and store share clk_sys.
interface hdt_reg_if #(parameter int WIDTH = 8);
   logic               wr_en;
   logic [WIDTH-1:0]   wr_data;
   logic [WIDTH/8-1:0] wr_be;
   logic [WIDTH-1:0]   value;
   logic               locked;

   modport ctrl  (output wr_en, output wr_data, output wr_be, input value, input locked);
   modport store (input wr_en, input wr_data, input wr_be, output value, output locked);
endinterface

// ### verilog/hdt_field_reg.sv
// Byte-enabled configuration field, optionally write-once.
// Assumes WIDTH is a multiple of eight and writes come from clk_sys logic.
module hdt_field_reg #(
   parameter int               WIDTH       = 8,
   parameter bit               WRITE_ONCE  = 1'b0,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Field port
   hdt_reg_if.store port
);

   typedef struct packed {
      logic [WIDTH-1:0] value;
      logic             locked;
   } hdt_field_state_t;

   hdt_field_state_t state;
   hdt_field_state_t next_state;

   // Merge enabled lanes; a write-once field closes on its first write
   always_comb
   begin
      next_state = state;
      if (port.wr_en && !state.locked)
      begin
         for (int i = 0; i < WIDTH / 8; i++)
         begin
            if (port.wr_be[i])
               next_state.value[i*8 +: 8] = port.wr_data[i*8 +: 8];
         end
         next_state.locked = WRITE_ONCE;
      end
   end

   // Only reset reopens a locked field
   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         state <= '{value: RESET_VALUE, locked: 1'b0};
      else
         state <= next_state;
   end

   assign port.value  = state.value;
   assign port.locked = state.locked;

endmodule // hdt_field_reg

// ### verilog/hdt_cfg_decode.sv
// Dword address decoder for the header tail.
// Assumes the dword address is byte address bits 7:2.
module hdt_cfg_decode (
   // Request
   input  wire logic                         req,
   input  wire logic [5:0]                   dword_addr,
   // Result
   output logic      [hdt_pkg::HIT_COUNT-1:0] hit,
   output logic                              mapped
);

   logic [5:0] dw [hdt_pkg::HIT_COUNT];

   // Table of dwords owned, indexed by hit number
   assign dw[hdt_pkg::HIT_SUBSYS]  = hdt_pkg::OFS_SUBSYSTEM_IDENT[7:2];
   assign dw[hdt_pkg::HIT_ROM]     = hdt_pkg::OFS_ROM_BASE_WINDOW[7:2];
   assign dw[hdt_pkg::HIT_CAPPTR]  = hdt_pkg::OFS_FIRST_CAPABILITY[7:2];
   assign dw[hdt_pkg::HIT_IRQ]     = hdt_pkg::OFS_IRQ_ROUTING_LINE[7:2];
   assign dw[hdt_pkg::HIT_MIRROR]  = hdt_pkg::OFS_MIRRORED_CAPABILITY[7:2];
   assign dw[hdt_pkg::HIT_CAPBLK0] = hdt_pkg::OFS_VENDOR_CAP_BLOCK[7:2];
   assign dw[hdt_pkg::HIT_CAPBLK1] = hdt_pkg::OFS_VENDOR_CAP_BLOCK_MID[7:2];
   assign dw[hdt_pkg::HIT_CAPBLK2] = hdt_pkg::OFS_VENDOR_CAP_BLOCK_TOP[7:2];

   // One-hot compare
   always_comb
   begin
      for (int i = 0; i < hdt_pkg::HIT_COUNT; i++)
         hit[i] = req && (dword_addr == dw[i]);
   end

   assign mapped = |hit;

endmodule // hdt_cfg_decode

// ### verilog/hdt_header_tail.sv
// Upper configuration header of the integrated graphics function.
// Assumes config cycles arrive as one-cycle requests from logic on clk_sys;
// the answer comes one cycle later, so the requester never needs to stall.
module hdt_header_tail (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Configuration cycle request
   input  wire logic        cfg_req,
   input  wire logic        cfg_write,
   input  wire logic [5:0]  cfg_dword_addr,
   input  wire logic [3:0]  cfg_byte_en,
   input  wire logic [31:0] cfg_wdata,
   // Configuration cycle answer
   output logic             cfg_done,
   output logic             cfg_claimed,
   output logic      [31:0] cfg_rdata,
   // Selection from the function's capability-list control
   input  wire logic        capability_list_select,
   // Status toward the rest of the function
   output logic      [15:0] subsystem_identifier,
   output logic             subsystem_locked,
   output logic      [7:0]  irq_routing_field,
   output logic             rom_decode_enable,
   output logic             write_ignored
);

   ////////////////////////////////////////////////////////////////////////////////
   // Byte lanes of sub-dword registers

   localparam int LANE_SUBSYS = int'(hdt_pkg::OFS_SUBSYSTEM_IDENT[1:0]);
   localparam int LANE_CAPPTR = int'(hdt_pkg::OFS_FIRST_CAPABILITY[1:0]);
   localparam int LANE_LINE   = int'(hdt_pkg::OFS_IRQ_ROUTING_LINE[1:0]);
   localparam int LANE_PIN    = int'(hdt_pkg::OFS_IRQ_PIN_SELECT[1:0]);
   localparam int LANE_GNT    = int'(hdt_pkg::OFS_MIN_GRANT_VALUE[1:0]);
   localparam int LANE_LAT    = int'(hdt_pkg::OFS_MAX_LATENCY_VALUE[1:0]);
   localparam int LANE_MIRROR = int'(hdt_pkg::OFS_MIRRORED_CAPABILITY[1:0]);

   ////////////////////////////////////////////////////////////////////////////////
   // Fixed words

   // Whole ROM window is hardwired: base, size mask, reserved and enable
   localparam logic [31:0] ROM_WORD = hdt_pkg::RST_ROM_BASE_WINDOW;

   // Low dword of the vendor capability block, kept in step with the bridge copy
   localparam logic [31:0] CAPBLK_LOW_WORD =
      (32'(hdt_pkg::VAL_CAPABILITY_VERSION) << hdt_pkg::POS_CAPABILITY_VERSION)
    | (32'(hdt_pkg::VAL_CAPABILITY_LENGTH)  << hdt_pkg::POS_CAPABILITY_LENGTH)
    | (32'(hdt_pkg::VAL_NEXT_CAPABILITY)    << hdt_pkg::POS_NEXT_CAPABILITY)
    | (32'(hdt_pkg::VAL_CAPABILITY_ID)      << hdt_pkg::POS_CAPABILITY_ID);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic        done;
      logic        claimed;
      logic [31:0] rdata;
      logic        ignored;
      logic        rom_enable;
   } hdt_state_t;

   hdt_state_t state;
   hdt_state_t next_state;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   logic [hdt_pkg::HIT_COUNT-1:0] hit;
   logic                          mapped;

   hdt_cfg_decode u_decode (
      .req        (cfg_req),
      .dword_addr (cfg_dword_addr),
      .hit        (hit),
      .mapped     (mapped)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Writable fields

   hdt_reg_if #(.WIDTH(16)) subsys_if ();
   hdt_reg_if #(.WIDTH(8))  line_if ();

   // Write-once identifier; firmware has a single chance at start-up
   hdt_field_reg #(
      .WIDTH       (16),
      .WRITE_ONCE  (1'b1),
      .RESET_VALUE (hdt_pkg::RST_SUBSYSTEM_IDENT)
   ) u_subsys (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .port    (subsys_if.store)
   );

   // Interrupt routing is storage only; it changes no interrupt behaviour
   hdt_field_reg #(
      .WIDTH       (8),
      .WRITE_ONCE  (1'b0),
      .RESET_VALUE (hdt_pkg::RST_IRQ_ROUTING_LINE)
   ) u_line (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .port    (line_if.store)
   );

   logic wr;
   logic subsys_lanes;
   logic line_lane;

   assign wr           = cfg_req && cfg_write;
   assign subsys_lanes = |cfg_byte_en[LANE_SUBSYS +: 2];
   assign line_lane    = cfg_byte_en[LANE_LINE];

   // Identifier write: either or both upper lanes of its dword
   assign subsys_if.wr_en   = wr && hit[hdt_pkg::HIT_SUBSYS] && subsys_lanes;
   assign subsys_if.wr_data = cfg_wdata[LANE_SUBSYS*8 +: 16];
   assign subsys_if.wr_be   = cfg_byte_en[LANE_SUBSYS +: 2];

   // Routing write: only its own lane; pin, grant and latency lanes drop
   assign line_if.wr_en   = wr && hit[hdt_pkg::HIT_IRQ] && line_lane;
   assign line_if.wr_data = cfg_wdata[LANE_LINE*8 +: 8];
   assign line_if.wr_be   = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // Read word assembly

   logic [7:0]  cap_pointer;
   logic [31:0] read_word;
   logic [31:0] lane_mask;

   // Pointer picks the MSI entry only when the list select bit is set
   assign cap_pointer = capability_list_select ? hdt_pkg::VAL_CAP_MSI
                                               : hdt_pkg::VAL_CAP_POWER_MGMT;

   // Disabled byte lanes read as zero
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         lane_mask[i*8 +: 8] = {8{cfg_byte_en[i]}};
   end

   // Fixed and stored values placed in their lanes; unowned lanes are zero
   always_comb
   begin
      read_word = 32'h0000_0000;
      if (hit[hdt_pkg::HIT_SUBSYS])
         read_word[LANE_SUBSYS*8 +: 16] = subsys_if.value;
      if (hit[hdt_pkg::HIT_ROM])
         read_word = ROM_WORD;
      if (hit[hdt_pkg::HIT_CAPPTR])
         read_word[LANE_CAPPTR*8 +: 8] = cap_pointer;
      if (hit[hdt_pkg::HIT_IRQ])
      begin
         read_word[LANE_LINE*8 +: 8] = line_if.value;
         read_word[LANE_PIN*8 +: 8]  = hdt_pkg::VAL_IRQ_PIN_SELECT;
         read_word[LANE_GNT*8 +: 8]  = hdt_pkg::VAL_MIN_GRANT;
         read_word[LANE_LAT*8 +: 8]  = hdt_pkg::VAL_MAX_LATENCY;
      end
      if (hit[hdt_pkg::HIT_MIRROR])
         read_word[LANE_MIRROR*8 +: 8] = hdt_pkg::VAL_MIRRORED_CAPABILITY;
      if (hit[hdt_pkg::HIT_CAPBLK0])
         read_word = CAPBLK_LOW_WORD;
      // Upper block dwords are reserved zero; the top dword's high half is
      // owned by the next register and also reads zero here
      if (hit[hdt_pkg::HIT_CAPBLK1] || hit[hdt_pkg::HIT_CAPBLK2])
         read_word = 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Dropped write detection

   logic ro_lanes_written;
   logic lock_blocked;

   // Any enabled lane of a read-only field, or a write after the lock
   always_comb
   begin
      ro_lanes_written = 1'b0;
      if (hit[hdt_pkg::HIT_SUBSYS])
         ro_lanes_written = |cfg_byte_en[LANE_SUBSYS-1:0];
      if (hit[hdt_pkg::HIT_ROM] || hit[hdt_pkg::HIT_CAPPTR] || hit[hdt_pkg::HIT_MIRROR]
          || hit[hdt_pkg::HIT_CAPBLK0] || hit[hdt_pkg::HIT_CAPBLK1]
          || hit[hdt_pkg::HIT_CAPBLK2])
         ro_lanes_written = |cfg_byte_en;
      if (hit[hdt_pkg::HIT_IRQ])
         ro_lanes_written = cfg_byte_en[LANE_PIN] || cfg_byte_en[LANE_GNT]
                            || cfg_byte_en[LANE_LAT];
   end

   assign lock_blocked = subsys_if.wr_en && subsys_if.locked;

   ////////////////////////////////////////////////////////////////////////////////
   // Answer and status registers

   // One answer per request, one cycle after it; data held until the next
   always_comb
   begin
      next_state            = state;
      next_state.done       = cfg_req;
      next_state.claimed    = mapped;
      next_state.ignored    = wr && (ro_lanes_written || lock_blocked);
      next_state.rom_enable = 1'b0;
      if (cfg_req && !cfg_write)
         next_state.rdata = read_word & lane_mask;
      else if (cfg_req)
         next_state.rdata = 32'h0000_0000;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!reset_n)
         state <= '0;
      else
         state <= next_state;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign cfg_done             = state.done;
   assign cfg_claimed          = state.claimed;
   assign cfg_rdata            = state.rdata;
   assign write_ignored        = state.ignored;
   assign rom_decode_enable    = state.rom_enable;
   assign subsystem_identifier = subsys_if.value;
   assign subsystem_locked     = subsys_if.locked;
   assign irq_routing_field    = line_if.value;

endmodule // hdt_header_tail

// ### testbench/hdt_header_tail_props.sv
// Checker for the header tail: fixed values, identifier lock and routing store.
// Assumes it is bound to hdt_header_tail and sees only that module's ports.
module hdt_header_tail_props (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        reset_n,
   // Request
   input wire logic        cfg_req,
   input wire logic        cfg_write,
   input wire logic [5:0]  cfg_dword_addr,
   input wire logic [3:0]  cfg_byte_en,
   input wire logic [31:0] cfg_wdata,
   input wire logic        capability_list_select,
   // Answer and status
   input wire logic        cfg_done,
   input wire logic        cfg_claimed,
   input wire logic [31:0] cfg_rdata,
   input wire logic [15:0] subsystem_identifier,
   input wire logic        subsystem_locked,
   input wire logic [7:0]  irq_routing_field,
   input wire logic        rom_decode_enable,
   input wire logic        write_ignored
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////
   // Decoded requests, short names keep the properties on one line
   logic       rd;
   logic       wr;
   logic [5:0] a;
   assign rd = cfg_req && !cfg_write;
   assign wr = cfg_req && cfg_write;
   assign a  = cfg_dword_addr;
   ////////////////////////////////////////////////////////////
   // Stored values captured at the request, compared at the answer
   property route_store_p;
      wr && a == 6'h0f && cfg_byte_en == 4'h1
         |=> irq_routing_field == $past(cfg_wdata[7:0]) && !write_ignored;
   endproperty
   property first_write_p;
      wr && a == 6'h0b && cfg_byte_en[3:2] == 2'b11 && !subsystem_locked
         |=> subsystem_locked && subsystem_identifier == $past(cfg_wdata[31:16]);
   endproperty
   chk_rom_reads_zero: assert property (rd && a == 6'h0c |=> cfg_rdata == 32'h0)
      else $error("rom base read not zero");
   chk_rom_no_decode: assert property (!rom_decode_enable)
      else $error("rom decode enabled");
   chk_cap_pointer_sel: assert property (rd && a == 6'h0d && cfg_byte_en[0]
      |=> cfg_rdata[7:0] == ($past(capability_list_select) ? 8'h90 : 8'hd0))
      else $error("capability pointer wrong");
   chk_irq_dword_read: assert property (rd && a == 6'h0f && cfg_byte_en == 4'hf
      |=> cfg_rdata == {16'h0000, 8'h01, irq_routing_field})
      else $error("interrupt dword wrong");
   chk_mirror_ptr_fixed: assert property (rd && a == 6'h11 && cfg_byte_en[0]
      |=> cfg_rdata[7:0] == 8'he0)
      else $error("mirrored pointer wrong");
   chk_cap_block_fixed: assert property (rd && a == 6'h12 && cfg_byte_en == 4'hf
      |=> cfg_rdata == 32'h0109_0009)
      else $error("capability block wrong");
   chk_first_write_locks: assert property (first_write_p)
      else $error("identifier first write not stored");
   chk_lock_sticks: assert property (subsystem_locked |=> subsystem_locked && $stable(subsystem_identifier))
      else $error("locked identifier changed");
   chk_unlocked_zero: assert property (!subsystem_locked |-> subsystem_identifier == 16'h0000)
      else $error("unlocked identifier not zero");
   chk_ro_write_flag: assert property (wr && a inside {6'h0c, 6'h11, 6'h12} && cfg_byte_en != 4'h0
      |=> write_ignored)
      else $error("read-only write not flagged");
   chk_route_store: assert property (route_store_p)
      else $error("routing byte not stored");
   // Main scenarios reached
   cov_locked_write: cover property (wr && a == 6'h0b && subsystem_locked ##1 write_ignored);
   cov_msi_pointer: cover property (rd && a == 6'h0d && capability_list_select);
   cov_route_write: cover property (wr && a == 6'h0f ##1 cfg_done);
endmodule // hdt_header_tail_props

bind hdt_header_tail hdt_header_tail_props u_props (
   .clk_sys(clk_sys), .reset_n(reset_n), .cfg_req(cfg_req), .cfg_write(cfg_write),
   .cfg_dword_addr(cfg_dword_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
   .capability_list_select(capability_list_select), .cfg_done(cfg_done),
   .cfg_claimed(cfg_claimed), .cfg_rdata(cfg_rdata), .subsystem_identifier(subsystem_identifier),
   .subsystem_locked(subsystem_locked), .irq_routing_field(irq_routing_field),
   .rom_decode_enable(rom_decode_enable), .write_ignored(write_ignored)
);

// ### testbench/hdt_host_model.sv
// Host configuration software model: one configuration cycle per call.
// Assumes the block answers within a few clk_sys cycles of taking a request.
module hdt_host_model (
   // Clock
   input  wire logic        clk_sys,
   // Request toward the block
   output logic             cfg_req,
   output logic             cfg_write,
   output logic [5:0]       cfg_dword_addr,
   output logic [3:0]       cfg_byte_en,
   output logic [31:0]      cfg_wdata,
   // Answer from the block
   input  wire logic        cfg_done,
   input  wire logic        cfg_claimed,
   input  wire logic [31:0] cfg_rdata,
   input  wire logic        write_ignored
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle at time zero, no request pending
   initial
   begin
      cfg_req = 1'b0;
      cfg_write = 1'b0;
      cfg_dword_addr = 6'h00;
      cfg_byte_en = 4'h0;
      cfg_wdata = 32'h0;
   end
   // One cycle; qualifiers flip once taken so stale values are never trusted
   task automatic access(input logic wr, input logic [5:0] a, input logic [3:0] be,
                         input logic [31:0] wd, output logic [31:0] rd, output logic cl,
                         output logic ign, output logic ok);
      int n;
      @(posedge clk_sys);
      cfg_req <= 1'b1;
      cfg_write <= wr;
      cfg_dword_addr <= a;
      cfg_byte_en <= be;
      cfg_wdata <= wd;
      @(posedge clk_sys);
      cfg_req <= 1'b0;
      cfg_write <= ~wr;
      cfg_dword_addr <= ~a;
      cfg_byte_en <= ~be;
      cfg_wdata <= ~wd;
      for (n = 0; n < 4; n++)
      begin
         #1;
         if (cfg_done === 1'b1)
            break;
         @(posedge clk_sys);
      end
      ok = (n < 4);
      rd = cfg_rdata;
      cl = cfg_claimed;
      ign = write_ignored;
   endtask
endmodule // hdt_host_model

// ### testbench/tb_top.sv
// Self-checking bench for the header tail: fixed values, lock, routing, random traffic.
// Assumes the host model issues one configuration cycle at a time.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////
   logic        clk_sys;
   logic        reset_n;
   logic        capability_list_select;
   logic        cfg_req;
   logic        cfg_write;
   logic [5:0]  cfg_dword_addr;
   logic [3:0]  cfg_byte_en;
   logic [31:0] cfg_wdata;
   logic        cfg_done;
   logic        cfg_claimed;
   logic [31:0] cfg_rdata;
   logic [15:0] subsystem_identifier;
   logic        subsystem_locked;
   logic [7:0]  irq_routing_field;
   logic        rom_decode_enable;
   logic        write_ignored;
   logic [15:0] m_id;
   logic        m_lock;
   logic [7:0]  m_route;
   logic [31:0] seed;
   int          num_errors;
   int          checks_done;
   logic [5:0]  tbl [8] = '{6'h0b, 6'h0c, 6'h0d, 6'h0f, 6'h11, 6'h12, 6'h13, 6'h14};
   ////////////////////////////////////////////////////////////
   hdt_header_tail dut (.clk_sys(clk_sys), .reset_n(reset_n), .cfg_req(cfg_req),
      .cfg_write(cfg_write), .cfg_dword_addr(cfg_dword_addr), .cfg_byte_en(cfg_byte_en),
      .cfg_wdata(cfg_wdata), .cfg_done(cfg_done), .cfg_claimed(cfg_claimed),
      .cfg_rdata(cfg_rdata), .capability_list_select(capability_list_select),
      .subsystem_identifier(subsystem_identifier), .subsystem_locked(subsystem_locked),
      .irq_routing_field(irq_routing_field), .rom_decode_enable(rom_decode_enable),
      .write_ignored(write_ignored));
   hdt_host_model host (.clk_sys(clk_sys), .cfg_req(cfg_req), .cfg_write(cfg_write),
      .cfg_dword_addr(cfg_dword_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
      .cfg_done(cfg_done), .cfg_claimed(cfg_claimed), .cfg_rdata(cfg_rdata),
      .write_ignored(write_ignored));
   // 100 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////
   // Expectation helpers; the model state mirrors what the block must hold
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] exp_read(input logic [5:0] a, input logic [3:0] be,
                                            input logic sel);
      logic [31:0] v;
      case (a)
         6'h0b: v = {m_id, 16'h0000};
         6'h0d: v = {24'h000000, sel ? 8'h90 : 8'hd0};
         6'h0f: v = {16'h0000, 8'h01, m_route};
         6'h11: v = 32'h0000_00e0;
         6'h12: v = 32'h0109_0009;
         default: v = 32'h0000_0000;
      endcase
      return v & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction
   // Only the identifier while open and the routing lane accept data
   function automatic logic exp_ign(input logic [5:0] a, input logic [3:0] be);
      case (a)
         6'h0b: return (|be[1:0]) || (m_lock && (|be[3:2]));
         6'h0f: return |be[3:1];
         default: return 1'b1;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      checks_done++;
      if (seen !== want)
      begin
         num_errors++;
         $display("ERROR %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask
   task automatic end_sim();
      $display("TB: checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Reset held n cycles; the model returns to its reset state with it
   task automatic do_reset(input int n);
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (n) @(posedge clk_sys);
      reset_n <= 1'b1;
      m_id = 16'h0000;
      m_lock = 1'b0;
      m_route = 8'h00;
      @(posedge clk_sys);
   endtask
   // One cycle through the host model, then every answer and status compared
   task automatic op(input logic wr, input logic [5:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
      logic [31:0] rd;
      logic        cl;
      logic        ign;
      logic        ok;
      logic        want_ign;
      want_ign = wr && exp_ign(a, be);
      host.access(wr, a, be, wd, rd, cl, ign, ok);
      if (ok !== 1'b1)
      begin
         num_errors++;
         $display("ERROR %0t: no answer", $time);
         end_sim();
      end
      check({31'h0, cl}, {31'h0, a inside {tbl}}, "claim");
      check(rd, wr ? 32'h0 : exp_read(a, be, capability_list_select), "data");
      check({31'h0, ign}, {31'h0, want_ign}, "ignored");
      if (wr && a == 6'h0b && (|be[3:2]) && !m_lock)
      begin
         m_id[7:0] = be[2] ? wd[23:16] : 8'h00;
         m_id[15:8] = be[3] ? wd[31:24] : 8'h00;
         m_lock = 1'b1;
      end
      if (wr && a == 6'h0f && be[0])
         m_route = wd[7:0];
      check({15'h0, subsystem_locked, subsystem_identifier}, {15'h0, m_lock, m_id}, "ident");
      check({23'h0, rom_decode_enable, irq_routing_field}, {24'h0, m_route}, "route");
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence: reset values, selection, read-only writes, lock, random mix
   initial
   begin
      num_errors = 0;
      checks_done = 0;
      seed = 32'ha75966f1;
      reset_n = 1'b0;
      capability_list_select = 1'b0;
      do_reset(8);
      foreach (tbl[i]) op(1'b0, tbl[i], 4'hf, 32'h0);
      op(1'b0, 6'h20, 4'hf, 32'h0);
      $display("TB: reset values done");
      @(posedge clk_sys);
      capability_list_select <= 1'b1;
      op(1'b0, 6'h0d, 4'h1, 32'h0);
      $display("TB: capability select done");
      foreach (tbl[i]) op(1'b1, tbl[i], 4'hf, 32'hffff_ffff);
      foreach (tbl[i]) op(1'b0, tbl[i], 4'hf, 32'h0);
      $display("TB: read-only writes done");
      // The sweep above locked the identifier; reopen it for the firmware write
      do_reset(1);
      op(1'b1, 6'h0b, 4'h4, 32'h00a5_0000);
      op(1'b1, 6'h0b, 4'hc, 32'h1234_0000);
      do_reset(3);
      op(1'b0, 6'h0b, 4'hc, 32'h0);
      op(1'b1, 6'h0b, 4'h8, 32'h5a00_0000);
      op(1'b1, 6'h0b, 4'hc, 32'hffff_0000);
      $display("TB: identifier lock done");
      do_reset(2);
      repeat (200)
      begin
         seed = lfsr_next(seed);
         @(posedge clk_sys);
         capability_list_select <= seed[9];
         op(seed[8], tbl[seed[2:0]], seed[7:4] == 4'h0 ? 4'hf : seed[7:4], lfsr_next(seed));
      end
      $display("TB: random traffic done");
      end_sim();
   end
endmodule // tb_top
